//--- hw/bscan_pkg.sv
// Types shared by the boundary-scan data register block.
// Assumes bscan_regs.svh is on the include path.
`include "bscan_regs.svh"

package bscan_pkg;

  // ----------------------------------------------------------------
  // TAP states and data register selection
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } bscan_tap_e;

  typedef enum logic [1:0] {SEL_CHAIN, SEL_BYP, SEL_ID} bscan_sel_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } bscan_jtag_s;

  // Drive request from the memory core for one data port
  typedef struct packed {
    logic [`BSCAN_DW-1:0] dat;
    logic en;
  } bscan_core_s;

  // Pin-side drive of one data port
  typedef struct packed {
    logic [`BSCAN_DW-1:0] o;
    logic [`BSCAN_DW-1:0] oe;
  } bscan_pin_s;

endpackage

//--- hw/bscan_regs.svh
// Constants of the boundary-scan data register block: codes, widths,
// capture values. Pure definitions, included by the package, the top module and the bench files.
//
// Function
// R1: SAMPLE routes boundary chain, system keeps running
// R2: SAMPLE capture loads system pin states
// R3: BYPASS routes one-bit register, system untouched
// R4: Capture-DR loads zero into bypass bit
// R5: Bypass bit changes only in Capture-DR and Shift-DR
// R6: Bypass passes bits without inversion
// R7: Bypass data leaves on falling test clock
// R8: EXTEST routes chain, captures input pins
// R9: EXTEST Update-DR drives output pins from chain
// R10: IDCODE routes, captures, shifts identification register
// R11: Update stage changes only in Update-DR
// R12: Capture-DR loads shift stage from pins
// R13: Chain shifts only in Shift-DR state
// R14: Chain passes data without inversion
// R15: Chain leaves LSB first on falling edge
// R16: Input-only cells merely observe their pins
// R17: Data port pins use data/enable/input cells
// R18: Test-Logic-Reset selects IDCODE
// R19: Codes 011 to 110 are unsupported
// R20: TDO driven only in shift states
// R21: Unsupported codes behave as bypass
// R22: Controller keeps TMS/TDI stable at rising edge
`ifndef BSCAN_REGS_SVH
`define BSCAN_REGS_SVH

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define BSCAN_IR_W 3
`define BSCAN_OP_EXTEST 3'h0
`define BSCAN_OP_IDCODE 3'h1
`define BSCAN_OP_SAMPLE 3'h2
`define BSCAN_OP_BYPASS 3'h7

// ----------------------------------------------------------------
// Capture values and widths
// ----------------------------------------------------------------
`define BSCAN_IR_CAPTURE 3'h1
`define BSCAN_BYP_CAPTURE 1'h0
`define BSCAN_ID_W 32
`define BSCAN_DW 8
`define BSCAN_N_IN 31

`endif

//--- hw/bscan_top.sv
// Boundary-scan TAP, instruction register and data registers
// (boundary cell chain, single-bit pass register, identification).
// Assumes the test clock and pins arrive asynchronously to clk and
// toggle far slower than clk; the memory core sits on clk.
`timescale 1ns/1ns
`include "bscan_regs.svh"

module bscan_top #(
  parameter int N_IN = `BSCAN_N_IN,
  // Arbitrary identification value, bit 0 fixed at one
  parameter logic [`BSCAN_ID_W-1:0] ID_VALUE = 32'h1000_0001
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Test port
  input wire bscan_pkg::bscan_jtag_s jtag,
  output logic tdo,
  output logic tdo_oe,
  // Input-only pins, observed only
  input wire logic [N_IN-1:0] sys_in,
  // Data port pins
  input wire logic [`BSCAN_DW-1:0] pin_a_i,
  input wire logic [`BSCAN_DW-1:0] pin_b_i,
  output bscan_pkg::bscan_pin_s pin_a,
  output bscan_pkg::bscan_pin_s pin_b,
  // Memory core side of the data ports
  input wire bscan_pkg::bscan_core_s core_a,
  input wire bscan_pkg::bscan_core_s core_b,
  output logic [`BSCAN_DW-1:0] core_a_i,
  output logic [`BSCAN_DW-1:0] core_b_i
);
  import bscan_pkg::*;

  // ----------------------------------------------------------------
  // Chain layout, index 0 sits next to TDO
  // ----------------------------------------------------------------
  localparam int DW = `BSCAN_DW;
  localparam int NS = N_IN + 2 * DW;
  localparam int A_IN = N_IN;
  localparam int B_IN = N_IN + DW;
  localparam int A_OUT = N_IN + 2 * DW;
  localparam int B_OUT = N_IN + 3 * DW;
  localparam int A_EN = N_IN + 4 * DW;
  localparam int B_EN = A_EN + 1;
  localparam int L = B_EN + 1;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic bscan_tap_e tap_next(bscan_tap_e s, logic tms);
    case (s)
      TAP_TLR: tap_next = tms ? TAP_TLR : TAP_RTI;
      TAP_RTI: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: tap_next = tms ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      default: tap_next = TAP_TLR;
    endcase
  endfunction

  function automatic bscan_sel_e sel_of(logic [`BSCAN_IR_W-1:0] op);
    case (op)
      `BSCAN_OP_EXTEST, `BSCAN_OP_SAMPLE: sel_of = SEL_CHAIN; // R1 R8
      `BSCAN_OP_IDCODE: sel_of = SEL_ID; // R10
      default: sel_of = SEL_BYP; // R3 R19 R21
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and test clock edges
  // ----------------------------------------------------------------
  bscan_jtag_s jtag_s1_q, jtag_s2_q;
  logic tck_s3_q;
  logic [NS-1:0] in_s1_q, in_s2_q;
  logic tck_rise, tck_fall, tap_rst;

  always_ff @(posedge clk) begin
    if (rst) begin
      jtag_s1_q <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
      jtag_s2_q <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
      tck_s3_q <= 1'b0;
      in_s1_q <= '0;
      in_s2_q <= '0;
    end else begin
      jtag_s1_q <= jtag;
      jtag_s2_q <= jtag_s1_q;
      tck_s3_q <= jtag_s2_q.tck;
      in_s1_q <= {pin_b_i, pin_a_i, sys_in};
      in_s2_q <= in_s1_q;
    end
  end

  // Edges are taken late by the synchroniser delay; test clock must
  // stay well below clk/4 for stable TMS/TDI at the sampled edge
  assign tck_rise = jtag_s2_q.tck & ~tck_s3_q; // R22
  assign tck_fall = ~jtag_s2_q.tck & tck_s3_q;
  assign tap_rst = ~jtag_s2_q.trst_n;

  // ----------------------------------------------------------------
  // TAP controller and instruction register
  // ----------------------------------------------------------------
  bscan_tap_e tap_q, tap_d;
  logic [`BSCAN_IR_W-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
  bscan_sel_e sel;

  always_comb begin
    tap_d = tap_q;
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    if (tap_rst) begin
      tap_d = TAP_TLR;
    end else if (tck_rise) begin
      case (tap_q)
        TAP_CAP_IR: ir_sh_d = `BSCAN_IR_CAPTURE;
        TAP_SH_IR: ir_sh_d = {jtag_s2_q.tdi, ir_sh_q[`BSCAN_IR_W-1:1]};
        TAP_UPD_IR: ir_d = ir_sh_q;
        default: ir_d = ir_q;
      endcase
      tap_d = tap_next(tap_q, jtag_s2_q.tms);
    end
    if (tap_d == TAP_TLR) begin
      ir_d = `BSCAN_OP_IDCODE; // R18
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tap_q <= TAP_TLR;
      ir_sh_q <= `BSCAN_IR_CAPTURE;
      ir_q <= `BSCAN_OP_IDCODE;
    end else begin
      tap_q <= tap_d;
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
    end
  end

  assign sel = sel_of(ir_q);

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  logic byp_q, byp_d;
  logic [`BSCAN_ID_W-1:0] id_q, id_d;
  logic [L-1:0] chain_q, chain_d, upd_q, upd_d, cap_vec;
  bscan_pin_s pin_a_q, pin_a_d, pin_b_q, pin_b_d;

  // Output cells capture what the pins are driven with right now,
  // which is the core under SAMPLE and the update stage under EXTEST
  assign cap_vec = {pin_b_q.oe[0], pin_a_q.oe[0], pin_b_q.o, pin_a_q.o, in_s2_q}; // R2 R12 R16

  always_comb begin
    byp_d = byp_q;
    id_d = id_q;
    chain_d = chain_q;
    upd_d = upd_q;
    if (tck_rise) begin
      case (tap_q)
        TAP_CAP_DR: begin
          case (sel)
            SEL_CHAIN: chain_d = cap_vec; // R8 R12
            SEL_ID: id_d = ID_VALUE; // R10
            default: byp_d = `BSCAN_BYP_CAPTURE; // R4
          endcase
        end
        TAP_SH_DR: begin
          case (sel)
            SEL_CHAIN: chain_d = {jtag_s2_q.tdi, chain_q[L-1:1]}; // R13 R14
            SEL_ID: id_d = {jtag_s2_q.tdi, id_q[`BSCAN_ID_W-1:1]}; // R10
            default: byp_d = jtag_s2_q.tdi; // R5 R6
          endcase
        end
        TAP_UPD_DR: begin
          if (sel == SEL_CHAIN) begin
            upd_d = chain_q; // R11
          end
        end
        default: upd_d = upd_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      byp_q <= 1'b0;
      id_q <= '0;
      chain_q <= '0;
      upd_q <= '0;
    end else begin
      byp_q <= byp_d;
      id_q <= id_d;
      chain_q <= chain_d;
      upd_q <= upd_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and core inputs
  // ----------------------------------------------------------------
  logic extest;
  logic [DW-1:0] core_a_i_d, core_b_i_d;

  assign extest = (ir_q == `BSCAN_OP_EXTEST);

  always_comb begin
    // Two cells per data bit (output data, input data), one port enable cell per port
    pin_a_d.o = extest ? upd_q[A_OUT +: DW] : core_a.dat; // R9 R17
    pin_a_d.oe = {DW{extest ? upd_q[A_EN] : core_a.en}}; // R9 R17
    pin_b_d.o = extest ? upd_q[B_OUT +: DW] : core_b.dat; // R9 R17
    pin_b_d.oe = {DW{extest ? upd_q[B_EN] : core_b.en}}; // R9 R17
    // Core always sees the pins, the cells only observe them
    core_a_i_d = in_s2_q[A_IN +: DW]; // R1 R3 R16
    core_b_i_d = in_s2_q[B_IN +: DW];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_a_q <= '0;
      pin_b_q <= '0;
      core_a_i <= '0;
      core_b_i <= '0;
    end else begin
      pin_a_q <= pin_a_d;
      pin_b_q <= pin_b_d;
      core_a_i <= core_a_i_d;
      core_b_i <= core_b_i_d;
    end
  end

  assign pin_a = pin_a_q;
  assign pin_b = pin_b_q;

  // ----------------------------------------------------------------
  // TDO, updated on the falling test clock edge
  // ----------------------------------------------------------------
  logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;

  always_comb begin
    tdo_d = tdo_q;
    tdo_oe_d = tdo_oe_q;
    if (tap_rst) begin
      tdo_oe_d = 1'b0;
    end else if (tck_fall) begin
      tdo_oe_d = 1'b0;
      if (tap_q == TAP_SH_DR) begin
        tdo_oe_d = 1'b1; // R20
        case (sel)
          SEL_CHAIN: tdo_d = chain_q[0]; // R15
          SEL_ID: tdo_d = id_q[0];
          default: tdo_d = byp_q; // R7
        endcase
      end else if (tap_q == TAP_SH_IR) begin
        tdo_oe_d = 1'b1; // R20
        tdo_d = ir_sh_q[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_bypass_capture: assert property ( // R4
    tck_rise && !tap_rst && tap_q == TAP_CAP_DR && sel == SEL_BYP |=> !byp_q)
    else $error("bypass bit not cleared on capture");

  a_bypass_hold: assert property ( // R5
    $changed(byp_q) |-> $past(tck_rise) && $past(tap_q) inside {TAP_CAP_DR, TAP_SH_DR})
    else $error("bypass bit changed outside capture or shift");

  a_bypass_pass: assert property ( // R6
    tck_rise && !tap_rst && tap_q == TAP_SH_DR && sel == SEL_BYP |=> byp_q == $past(jtag_s2_q.tdi))
    else $error("bypass bit differs from shifted-in bit");

  a_tdo_falling: assert property ( // R7
    $changed(tdo_q) |-> $past(tck_fall))
    else $error("tdo changed away from a falling edge");

  a_chain_shift: assert property ( // R14
    tck_rise && !tap_rst && tap_q == TAP_SH_DR && sel == SEL_CHAIN
    |=> chain_q == {$past(jtag_s2_q.tdi), $past(chain_q[L-1:1])})
    else $error("chain shift lost or altered a bit");

  a_chain_hold: assert property ( // R13
    $changed(chain_q) |-> $past(tck_rise) && $past(tap_q) inside {TAP_CAP_DR, TAP_SH_DR})
    else $error("chain changed outside capture or shift");

  a_update_hold: assert property ( // R11
    $changed(upd_q) |-> $past(tck_rise) && $past(tap_q) == TAP_UPD_DR)
    else $error("update stage changed outside update");

  a_extest_drive: assert property ( // R9
    extest && $past(extest) |-> pin_a_q.o == $past(upd_q[A_OUT +: DW]) && pin_b_q.oe[0] == $past(upd_q[B_EN]))
    else $error("pins not driven from update stage under extest");

  a_system_drive: assert property ( // R1
    !extest |=> pin_a_q.o == $past(core_a.dat) && pin_b_q.o == $past(core_b.dat))
    else $error("pins not connected to the core");

  a_reset_idcode: assert property ( // R18
    tap_q == TAP_TLR |-> ir_q == `BSCAN_OP_IDCODE)
    else $error("instruction not idcode in test-logic-reset");

  a_id_capture: assert property ( // R10
    tck_rise && !tap_rst && tap_q == TAP_CAP_DR && sel == SEL_ID |=> id_q == ID_VALUE)
    else $error("identification value not captured");

  a_unsupported_byp: assert property ( // R21
    ir_q inside {3'h3, 3'h4, 3'h5, 3'h6} |-> sel == SEL_BYP && !extest)
    else $error("unsupported code not routed to bypass");

  a_tdo_enable: assert property ( // R20
    $rose(tdo_oe_q) |-> $past(tap_q) inside {TAP_SH_DR, TAP_SH_IR} ##0 $past(tck_fall))
    else $error("tdo enabled outside a shift state");

  c_extest_update: cover property (extest && tck_rise && tap_q == TAP_UPD_DR);
  c_bypass_shift: cover property (sel == SEL_BYP && tck_rise && tap_q == TAP_SH_DR);
  c_id_shift: cover property (sel == SEL_ID && tdo_oe_q && tap_q == TAP_SH_DR);
  c_sample_capture: cover property (ir_q == `BSCAN_OP_SAMPLE && tck_rise && tap_q == TAP_CAP_DR);

endmodule

//--- testbench/bscan_ctrl_model.sv
// Test controller model: drives tck, tms, tdi and trst_n, samples tdo.
// Assumes the bench clock clk; tck stands low between frames.
`timescale 1ns/1ns
`include "bscan_regs.svh"

module bscan_ctrl_model (
  // Clock
  input wire logic clk,
  // Test port
  output bscan_pkg::bscan_jtag_s jtag,
  input wire logic tdo,
  input wire logic tdo_oe
);
  import bscan_pkg::*;

  // Half period in clk cycles; raise it to act as a slow controller
  int half = 8;
  int port_err = 0;
  logic so;
  logic soe;

  // Idle levels follow the pin pulls: tck low, tms and tdi high
  initial jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};

  // ----------------------------------------------------------------
  // One test clock period
  // ----------------------------------------------------------------
  task automatic tick(input logic ms, input logic di);
    @(negedge clk);
    jtag.tms = ms;
    jtag.tdi = di;
    repeat (half) @(negedge clk);
    so = tdo;
    soe = tdo_oe;
    jtag.tck = 1'b1;
    repeat (half) @(negedge clk);
    // tdo may only move after the fall, so it must still hold here
    if (tdo !== so) port_err++;
    jtag.tck = 1'b0;
  endtask

  task automatic reset_tap();
    repeat (5) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
  endtask

  task automatic test_reset();
    jtag.trst_n = 1'b0;
    repeat (10) @(negedge clk);
    jtag.trst_n = 1'b1;
    repeat (4) @(negedge clk);
    tick(1'b0, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Scan n bits from Run-Test/Idle; pau >= 0 parks in Pause once
  // ----------------------------------------------------------------
  task automatic scan(input logic ir, input int n, input int pau, input logic [64:0] din,
                      output logic [64:0] dout);
    dout = '0;
    tick(1'b1, 1'b1);
    if (ir) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1 || i == pau, din[i]);
      dout[i] = so;
      if (soe !== 1'b1) port_err++;
      if (i == pau) begin
        tick(1'b0, 1'b1);
        tick(1'b0, 1'b1);
        if (soe !== 1'b0) port_err++;
        tick(1'b1, 1'b1);
        tick(1'b0, 1'b1);
      end
    end
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    jtag.tms = 1'b1;
  endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench of the boundary-scan data registers.
// Assumes bscan_pkg and the controller model are compiled first.
`timescale 1ns/1ns
`include "bscan_regs.svh"

module testbench;
  import bscan_pkg::*;

  // Arbitrary identification value, bit 0 set
  localparam logic [`BSCAN_ID_W-1:0] ID = 32'h2000_0003;
  localparam logic [30:0] SYS = 31'h5A3C_0F96;
  localparam logic [7:0] PA = 8'hC3;
  localparam logic [7:0] PB = 8'h5E;
  localparam logic [7:0] ADAT = 8'hA5;
  localparam logic [64:0] DIN = 65'h1_2345_6789_ABCD_EF01;
  localparam logic [64:0] BYP = 65'({DIN[6:0], 1'b0});

  typedef struct {logic [2:0] ir; int n; logic [64:0] exp;} bscan_row_s;

  logic clk = 1'b0;
  logic rst;
  bscan_jtag_s jtag;
  logic tdo;
  logic tdo_oe;
  logic [30:0] sys_in;
  logic [7:0] pin_a_i;
  logic [7:0] pin_b_i;
  bscan_pin_s pin_a;
  bscan_pin_s pin_b;
  bscan_core_s core_a;
  bscan_core_s core_b;
  logic [7:0] core_a_i;
  logic [7:0] core_b_i;
  logic [64:0] d;
  int num_errors = 0;
  int checks_done = 0;

  // Chain capture under SAMPLE: enables, output data, pin inputs, inputs
  bscan_row_s rows [7] = '{
    '{`BSCAN_OP_IDCODE, 32, 65'(ID)},
    '{`BSCAN_OP_SAMPLE, 65, {2'b01, 8'h00, ADAT, PB, PA, SYS}},
    '{3'h3, 8, BYP}, '{3'h4, 8, BYP}, '{3'h5, 8, BYP}, '{3'h6, 8, BYP},
    '{`BSCAN_OP_BYPASS, 8, BYP}
  };

  always #5 clk = ~clk;

  bscan_top #(.ID_VALUE(ID)) i_dut (.clk(clk), .rst(rst), .jtag(jtag), .tdo(tdo), .tdo_oe(tdo_oe),
    .sys_in(sys_in), .pin_a_i(pin_a_i), .pin_b_i(pin_b_i), .pin_a(pin_a), .pin_b(pin_b),
    .core_a(core_a), .core_b(core_b), .core_a_i(core_a_i), .core_b_i(core_b_i));

  bscan_ctrl_model i_ctrl (.clk(clk), .jtag(jtag), .tdo(tdo), .tdo_oe(tdo_oe));

  // ----------------------------------------------------------------
  // Shared checking
  // ----------------------------------------------------------------
  task automatic check(input logic [64:0] got, input logic [64:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    sys_in = SYS;
    pin_a_i = PA;
    pin_b_i = PB;
    core_a = '{dat: ADAT, en: 1'b1};
    core_b = '{dat: 8'h00, en: 1'b0};
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(65'(tdo_oe), 65'h0);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    i_ctrl.reset_tap();
    foreach (rows[k]) begin
      i_ctrl.scan(1'b1, 3, -1, 65'(rows[k].ir), d);
      i_ctrl.scan(1'b0, rows[k].n, -1, DIN, d);
      check(d & ((65'h1 << rows[k].n) - 65'h1), rows[k].exp);
      check(65'({pin_a, pin_b, core_a_i, core_b_i}), 65'({ADAT, 8'hFF, 16'h0, PA, PB}));
      check(65'(tdo_oe), 65'h0);
    end
    // EXTEST drives the pins from what SAMPLE left in the update stage
    i_ctrl.scan(1'b1, 3, -1, 65'(`BSCAN_OP_EXTEST), d);
    repeat (4) @(negedge clk);
    check(65'({pin_a, pin_b}), 65'({DIN[54:47], {8{DIN[63]}}, DIN[62:55], {8{DIN[64]}}}));
    i_ctrl.half = 13;
    i_ctrl.scan(1'b0, 65, 40, ~DIN, d);
    check(d, {DIN[64:47], PB, PA, SYS});
    core_a = '{dat: 8'h0F, en: 1'b0};
    repeat (4) @(negedge clk);
    check(65'({pin_a, pin_b}), 65'({~DIN[54:47], {8{~DIN[63]}}, ~DIN[62:55], {8{~DIN[64]}}}));
    check(65'({core_a_i, core_b_i}), 65'({PA, PB}));
    i_ctrl.half = 8;
    // Test reset must bring back the identification path, no instruction load
    i_ctrl.test_reset();
    i_ctrl.scan(1'b0, 32, 10, DIN, d);
    check(65'(d[31:0]), 65'(ID));
    check(65'({pin_a, pin_b}), 65'({8'h0F, 8'h00, 16'h0}));
    check(65'(i_ctrl.port_err), 65'h0);
    results();
  end

  // Cuts a hang short
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule
